// [design/timer2_capture_reload_control.sv]
/*
 Timer 2 of an 8-bit controller: 16-bit counter with capture, auto-reload,
 up/down counting, baud-rate generation and clock-out, plus its registers.
 Assumes a register port with read data one cycle after the read strobe,
 a same-clock Timer 1 overflow pulse and a same-clock interrupt enable.
*/
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// - Outside baud mode, overflow or down-count match sets overflow flag; software clears.
// - Trigger falling edge with trigger enable and no down count sets event flag.
// - A set event flag requests the Timer 2 interrupt when enabled.
// - Receive baud source picks Timer 2 or Timer 1 overflow for reception.
// - Transmit baud source picks Timer 2 or Timer 1 overflow for transmission.
// - In reload or capture mode, trigger enable lets a falling edge capture or reload.
// - Run control enables counting; cleared, both counter bytes hold except for a trigger edge reload.
// - Counter/timer select picks prescaled core ticks or trigger pin falling edges.
// - Capture/reload select chooses reload on overflow/edge or capture on edge.
// - Either baud source set forces auto-reload and ignores capture select.
// - Clock-out enable turns the Timer 2 clock output on or off.
// - With down count enabled, trigger pin level sets direction in auto-reload.
// - Low capture register takes low count byte or gives low reload byte.
// - High capture register takes high count byte or gives high reload byte.
// - Prescale select picks divide by 6 or 12; twelve-clock option forces 12.
module timer2_capture_reload_control (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // External trigger pin
    input wire logic external_trigger_pin,
    // Option and system inputs
    input wire logic twelve_clock_mode,
    input wire logic timer1_overflow,
    input wire logic timer2_int_enable,
    // Serial port time bases
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    // Interrupt request
    output logic timer2_irq,
    // Clock output pin
    output logic clock_out_pin,
    output logic clock_out_oe_n
);

    // Decode the operating mode from the control bits
    function automatic timer2_pkg::mode_e decode_mode(
        input logic rx_src,
        input logic tx_src,
        input logic cap_sel,
        input logic down_en
    );
        timer2_pkg::mode_e m;
        if (rx_src | tx_src) begin
            m = timer2_pkg::MODE_BAUD;
        end else if (cap_sel) begin
            m = timer2_pkg::MODE_CAPTURE;
        end else if (down_en) begin
            m = timer2_pkg::MODE_UPDOWN;
        end else begin
            m = timer2_pkg::MODE_RELOAD;
        end
        return m;
    endfunction

    logic rst_sync_a;
    logic rst_n;

    // Control register bits
    logic overflow_flag;
    logic external_event_flag;
    logic rx_baud_source;
    logic tx_baud_source;
    logic external_trigger_enable;
    logic run_control;
    logic counter_timer_select;
    logic capture_reload_select;
    // Mode and clock control bits
    logic clock_out_enable;
    logic down_count_enable;
    logic prescale_select;
    // Data registers
    logic [7:0] reload_capture_low;
    logic [7:0] reload_capture_high;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;

    logic [3:0] prescale_count;
    logic [3:0] prescale_div;
    logic prescale_tick;

    logic trigger_level;
    logic trigger_fall;

    timer2_pkg::mode_e mode;
    logic [15:0] count;
    logic [15:0] reload_value;
    logic [15:0] next_count;
    logic count_tick;
    logic count_up;
    logic overflow_up;
    logic match_down;
    logic timer_overflow;
    logic ext_trigger;
    logic set_overflow;
    logic set_event;
    logic wr_control;
    logic wr_mode;
    logic wr_clock_control;
    logic [7:0] control_value;
    logic [7:0] mode_value;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync_a <= 1'b1;
            rst_n <= rst_sync_a;
        end
    end

    trigger_sync u_trigger_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_async(external_trigger_pin),
        .level(trigger_level),
        .fall(trigger_fall)
    );

    assign wr_control = reg_write && (reg_addr == timer2_pkg::OFFS_CONTROL);
    assign wr_mode = reg_write && (reg_addr == timer2_pkg::OFFS_MODE);
    assign wr_clock_control = reg_write && (reg_addr == timer2_pkg::OFFS_CLOCK_CONTROL);

    assign mode = decode_mode(rx_baud_source, tx_baud_source, capture_reload_select, down_count_enable);
    assign count = {count_high_byte, count_low_byte};
    assign reload_value = {reload_capture_high, reload_capture_low};

    assign prescale_div = (twelve_clock_mode | prescale_select) ? timer2_pkg::PRESCALE_DIV12
                                                                : timer2_pkg::PRESCALE_DIV6;

    // Prescaler for timer mode
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_count <= 4'h0;
            prescale_tick <= 1'b0;
        end else begin
            if (prescale_count >= prescale_div - 4'h1) begin
                prescale_count <= 4'h0;
                prescale_tick <= 1'b1;
            end else begin
                prescale_count <= prescale_count + 4'h1;
                prescale_tick <= 1'b0;
            end
        end
    end

    always_comb begin
        count_tick = run_control & (counter_timer_select ? trigger_fall : prescale_tick);
        count_up = !((mode == timer2_pkg::MODE_UPDOWN) && !trigger_level);
        overflow_up = count_tick && count_up && (count == timer2_pkg::COUNT_MAX);
        match_down = count_tick && !count_up && (count == reload_value);
        timer_overflow = overflow_up | match_down;
        // trigger ignored in baud and up/down modes
        ext_trigger = trigger_fall && external_trigger_enable &&
                      ((mode == timer2_pkg::MODE_RELOAD) || (mode == timer2_pkg::MODE_CAPTURE));
        // overflow flag only outside baud mode
        set_overflow = timer_overflow && (mode != timer2_pkg::MODE_BAUD);
        set_event = trigger_fall && external_trigger_enable && !down_count_enable;
    end

    always_comb begin
        next_count = count;
        if (ext_trigger && (mode == timer2_pkg::MODE_RELOAD)) begin
            next_count = reload_value;
        end else if (overflow_up) begin
            if (mode == timer2_pkg::MODE_CAPTURE) begin
                next_count = timer2_pkg::COUNT_ZERO;
            end else begin
                next_count = reload_value;
            end
        end else if (match_down) begin
            next_count = timer2_pkg::COUNT_MAX;
        end else if (count_tick) begin
            if (count_up) begin
                next_count = count + 16'h0001;
            end else begin
                next_count = count - 16'h0001;
            end
        end
    end

    // Counter bytes; a software write wins over counting
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_low_byte <= timer2_pkg::COUNT_RESET;
            count_high_byte <= timer2_pkg::COUNT_RESET;
        end else begin
            if (reg_write && (reg_addr == timer2_pkg::OFFS_COUNT_LOW)) begin
                count_low_byte <= reg_wdata;
            end else begin
                count_low_byte <= next_count[7:0];
            end
            if (reg_write && (reg_addr == timer2_pkg::OFFS_COUNT_HIGH)) begin
                count_high_byte <= reg_wdata;
            end else begin
                count_high_byte <= next_count[15:8];
            end
        end
    end

    // Reload/capture registers; capture wins over a write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reload_capture_low <= timer2_pkg::RCAP_RESET;
            reload_capture_high <= timer2_pkg::RCAP_RESET;
        end else if (ext_trigger && (mode == timer2_pkg::MODE_CAPTURE)) begin
            reload_capture_low <= count_low_byte;
            reload_capture_high <= count_high_byte;
        end else if (reg_write && (reg_addr == timer2_pkg::OFFS_RCAP_LOW)) begin
            reload_capture_low <= reg_wdata;
        end else if (reg_write && (reg_addr == timer2_pkg::OFFS_RCAP_HIGH)) begin
            reload_capture_high <= reg_wdata;
        end
    end

    // Control bits written by software
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_baud_source <= timer2_pkg::CONTROL_RESET[timer2_pkg::BIT_RX_BAUD_SOURCE];
            tx_baud_source <= timer2_pkg::CONTROL_RESET[timer2_pkg::BIT_TX_BAUD_SOURCE];
            external_trigger_enable <= timer2_pkg::CONTROL_RESET[timer2_pkg::BIT_EXTERNAL_TRIGGER_ENABLE];
            run_control <= timer2_pkg::CONTROL_RESET[timer2_pkg::BIT_RUN_CONTROL];
            counter_timer_select <= timer2_pkg::CONTROL_RESET[timer2_pkg::BIT_COUNTER_TIMER_SELECT];
            capture_reload_select <= timer2_pkg::CONTROL_RESET[timer2_pkg::BIT_CAPTURE_RELOAD_SELECT];
        end else if (wr_control) begin
            rx_baud_source <= reg_wdata[timer2_pkg::BIT_RX_BAUD_SOURCE];
            tx_baud_source <= reg_wdata[timer2_pkg::BIT_TX_BAUD_SOURCE];
            external_trigger_enable <= reg_wdata[timer2_pkg::BIT_EXTERNAL_TRIGGER_ENABLE];
            run_control <= reg_wdata[timer2_pkg::BIT_RUN_CONTROL];
            counter_timer_select <= reg_wdata[timer2_pkg::BIT_COUNTER_TIMER_SELECT];
            capture_reload_select <= reg_wdata[timer2_pkg::BIT_CAPTURE_RELOAD_SELECT];
        end
    end

    // Flags: hardware set wins over a software clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= timer2_pkg::CONTROL_RESET[timer2_pkg::BIT_OVERFLOW_FLAG];
            external_event_flag <= timer2_pkg::CONTROL_RESET[timer2_pkg::BIT_EXTERNAL_EVENT_FLAG];
        end else begin
            if (set_overflow) begin
                overflow_flag <= 1'b1;
            end else if (wr_control) begin
                overflow_flag <= reg_wdata[timer2_pkg::BIT_OVERFLOW_FLAG];
            end
            if (set_event) begin
                external_event_flag <= 1'b1;
            end else if (wr_control) begin
                external_event_flag <= reg_wdata[timer2_pkg::BIT_EXTERNAL_EVENT_FLAG];
            end
        end
    end

    // Mode and clock control bits
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clock_out_enable <= timer2_pkg::MODE_RESET[timer2_pkg::BIT_CLOCK_OUT_ENABLE];
            down_count_enable <= timer2_pkg::MODE_RESET[timer2_pkg::BIT_DOWN_COUNT_ENABLE];
            prescale_select <= timer2_pkg::CLOCK_CONTROL_RESET[timer2_pkg::BIT_PRESCALE_SELECT];
        end else begin
            if (wr_mode) begin
                clock_out_enable <= reg_wdata[timer2_pkg::BIT_CLOCK_OUT_ENABLE];
                down_count_enable <= reg_wdata[timer2_pkg::BIT_DOWN_COUNT_ENABLE];
            end
            if (wr_clock_control) begin
                prescale_select <= reg_wdata[timer2_pkg::BIT_PRESCALE_SELECT];
            end
        end
    end

    // Interrupt request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer2_irq <= 1'b0;
        end else begin
            timer2_irq <= timer2_int_enable & (external_event_flag | overflow_flag);
        end
    end

    // Serial port time bases
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
        end else begin
            rx_baud_tick <= rx_baud_source ? timer_overflow : timer1_overflow;
            tx_baud_tick <= tx_baud_source ? timer_overflow : timer1_overflow;
        end
    end

    // Clock output toggles on each overflow
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clock_out_pin <= 1'b0;
            clock_out_oe_n <= 1'b1;
        end else begin
            clock_out_oe_n <= ~clock_out_enable;
            if (!clock_out_enable) begin
                clock_out_pin <= 1'b0;
            end else if (timer_overflow) begin
                clock_out_pin <= ~clock_out_pin;
            end
        end
    end

    assign control_value = {overflow_flag, external_event_flag, rx_baud_source, tx_baud_source,
                            external_trigger_enable, run_control, counter_timer_select, capture_reload_select};
    assign mode_value = {6'h00, clock_out_enable, down_count_enable};

    // Read data one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= timer2_pkg::READ_UNMAPPED;
        end else if (reg_read) begin
            case (reg_addr)
                timer2_pkg::OFFS_CONTROL: reg_rdata <= control_value;
                timer2_pkg::OFFS_MODE: reg_rdata <= mode_value;
                timer2_pkg::OFFS_RCAP_LOW: reg_rdata <= reload_capture_low;
                timer2_pkg::OFFS_RCAP_HIGH: reg_rdata <= reload_capture_high;
                timer2_pkg::OFFS_COUNT_LOW: reg_rdata <= count_low_byte;
                timer2_pkg::OFFS_COUNT_HIGH: reg_rdata <= count_high_byte;
                timer2_pkg::OFFS_CLOCK_CONTROL: reg_rdata <= {2'h0, prescale_select, 5'h00};
                default: reg_rdata <= timer2_pkg::READ_UNMAPPED;
            endcase
        end else begin
            reg_rdata <= timer2_pkg::READ_UNMAPPED;
        end
    end

endmodule

// [design/timer2_pkg.sv]
/*
 Shared constants for the Timer 2 capture/reload block: register offsets,
 bit positions, reset values, prescale counts and the operating mode enum.
 Assumes an 8-bit register port with 8-bit addresses.
*/
package timer2_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFFS_CONTROL = 8'hc8;
    localparam logic [7:0] OFFS_MODE = 8'hc9;
    localparam logic [7:0] OFFS_RCAP_LOW = 8'hca;
    localparam logic [7:0] OFFS_RCAP_HIGH = 8'hcb;
    localparam logic [7:0] OFFS_COUNT_LOW = 8'hcc;
    localparam logic [7:0] OFFS_COUNT_HIGH = 8'hcd;
    localparam logic [7:0] OFFS_CLOCK_CONTROL = 8'hdf;

    // Control register fields
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_EXTERNAL_EVENT_FLAG = 6;
    localparam int BIT_RX_BAUD_SOURCE = 5;
    localparam int BIT_TX_BAUD_SOURCE = 4;
    localparam int BIT_EXTERNAL_TRIGGER_ENABLE = 3;
    localparam int BIT_RUN_CONTROL = 2;
    localparam int BIT_COUNTER_TIMER_SELECT = 1;
    localparam int BIT_CAPTURE_RELOAD_SELECT = 0;

    // Mode register fields
    localparam int BIT_CLOCK_OUT_ENABLE = 1;
    localparam int BIT_DOWN_COUNT_ENABLE = 0;

    // Clock control register field
    localparam int BIT_PRESCALE_SELECT = 5;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] RCAP_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Prescale counts in core clock cycles
    localparam logic [3:0] PRESCALE_DIV6 = 4'h6;
    localparam logic [3:0] PRESCALE_DIV12 = 4'hc;

    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // Operating modes
    typedef enum logic [3:0] {
        MODE_RELOAD = 4'b0001,
        MODE_UPDOWN = 4'b0010,
        MODE_CAPTURE = 4'b0100,
        MODE_BAUD = 4'b1000
    } mode_e;

endpackage

// [design/trigger_sync.sv]
/*
 Synchroniser and falling edge detector for the external trigger pin.
 Assumes the pin is asynchronous to mclk; reset is already synchronised.
*/
`timescale 1ns/1ps
module trigger_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pin side
    input wire logic pin_async,
    // Core side
    output logic level,
    output logic fall
);

    logic meta;
    logic stable;
    logic stable_prev;

    // Two flop synchroniser
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b1;
            stable <= 1'b1;
        end else begin
            meta <= pin_async;
            stable <= meta;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stable_prev <= 1'b1;
        end else begin
            stable_prev <= stable;
        end
    end

    assign level = stable;
    assign fall = stable_prev & ~stable;

endmodule

// [test/tb_top.sv]
/*
 Self-checking bench for the Timer 2 block through its register port.
 Assumes the trigger_source model and the bound monitor.
*/
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic twelve_clock_mode = 1'b0;
    logic timer2_int_enable = 1'b0;
    logic [7:0] reg_rdata;
    logic trig_pin, t1_ovf, irq, cout_pin, cout_oe_n;
    logic [7:0] d;
    int bad_count = 0;
    int comparisons = 0;

    always #50 mclk = ~mclk;

    trigger_source partner (.mclk(mclk), .pin(trig_pin), .t1_ovf(t1_ovf));

    timer2_capture_reload_control dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .external_trigger_pin(trig_pin),
        .twelve_clock_mode(twelve_clock_mode), .timer1_overflow(t1_ovf), .timer2_int_enable(timer2_int_enable),
        .rx_baud_tick(), .tx_baud_tick(), .timer2_irq(irq), .clock_out_pin(cout_pin),
        .clock_out_oe_n(cout_oe_n));

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
        check(d, exp);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge mclk);
        bad_count++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        // Reset values, unmapped space, reserved bits
        for (int a = 8'hc8; a <= 8'hcd; a++) rdchk(a[7:0], 8'h00);
        rdchk(8'hdf, 8'h00);
        wr(8'hc0, 8'h5a);
        rdchk(8'hc0, 8'h00);
        wr(8'hc9, 8'hff);
        rdchk(8'hc9, 8'h03);
        check({7'h0, cout_oe_n}, 8'h00);
        partner.t1();
        $display("test registers done");
        // Stopped counter holds
        wr(8'hcc, 8'h55);
        wr(8'hcd, 8'h66);
        repeat (40) @(posedge mclk);
        rdchk(8'hcc, 8'h55);
        rdchk(8'hcd, 8'h66);
        $display("test hold done");
        // Overflow, reload, flag, interrupt, clock out
        wr(8'hca, 8'h34);
        wr(8'hcb, 8'h12);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        timer2_int_enable <= 1'b1;
        wr(8'hc8, 8'h04);
        repeat (40) @(posedge mclk);
        rdchk(8'hc8, 8'h84);
        check({7'h0, irq}, 8'h01);
        check({7'h0, cout_pin}, 8'h01);
        wr(8'hc8, 8'h00);
        rdchk(8'hcd, 8'h12);
        check({7'h0, irq}, 8'h00);
        wr(8'hc9, 8'h00);
        timer2_int_enable <= 1'b0;
        $display("test overflow done");
        // Capture on trigger edge
        wr(8'hcc, 8'hab);
        wr(8'hcd, 8'hcd);
        wr(8'hc8, 8'h09);
        partner.fall();
        rdchk(8'hca, 8'hab);
        rdchk(8'hcb, 8'hcd);
        rdchk(8'hc8, 8'h49);
        $display("test capture done");
        // Reload on trigger edge
        wr(8'hca, 8'h34);
        wr(8'hcb, 8'h12);
        wr(8'hcc, 8'h00);
        wr(8'hcd, 8'h00);
        wr(8'hc8, 8'h08);
        partner.fall();
        rdchk(8'hcc, 8'h34);
        rdchk(8'hcd, 8'h12);
        rdchk(8'hc8, 8'h48);
        $display("test reload done");
        // Baud mode ignores capture select; edges set only the event flag
        wr(8'hc8, 8'h39);
        wr(8'hcc, 8'h00);
        partner.fall();
        partner.t1();
        rdchk(8'hca, 8'h34);
        rdchk(8'hcc, 8'h00);
        rdchk(8'hc8, 8'h79);
        $display("test baud done");
        // Down count to reload match
        wr(8'hc8, 8'h00);
        wr(8'hc9, 8'h01);
        wr(8'hca, 8'h00);
        wr(8'hcb, 8'h00);
        wr(8'hcc, 8'h02);
        wr(8'hcd, 8'h00);
        wr(8'hc8, 8'h0c);
        partner.level(1'b0);
        repeat (40) @(posedge mclk);
        rdchk(8'hc8, 8'h8c);
        wr(8'hc8, 8'h00);
        rdchk(8'hcd, 8'hff);
        wr(8'hc9, 8'h00);
        partner.level(1'b1);
        $display("test down count done");
        // Counter mode counts pin edges
        wr(8'hcc, 8'h00);
        wr(8'hc8, 8'h06);
        repeat (3) partner.fall();
        wr(8'hc8, 8'h00);
        rdchk(8'hcc, 8'h03);
        $display("test counter done");
        // Prescale rates over 120 cycles
        for (int i = 0; i < 3; i++) begin
            wr(8'hdf, (i == 1) ? 8'h20 : 8'h00);
            twelve_clock_mode <= (i == 2);
            wr(8'hcc, 8'h00);
            wr(8'hcd, 8'h00);
            wr(8'hc8, 8'h04);
            repeat (118) @(posedge mclk);
            wr(8'hc8, 8'h00);
            rdchk(8'hcc, (i == 0) ? 8'h14 : 8'h0a);
        end
        $display("test prescale done");
        summarize();
    end
endmodule

// [test/timer2_monitor.sv]
/*
 Concurrent checks on the Timer 2 block ports.
 Assumes one clock domain and register writes that follow the register map.
*/
`timescale 1ns/1ps
module timer2_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Pins and system lines
    input wire logic external_trigger_pin,
    input wire logic twelve_clock_mode,
    input wire logic timer1_overflow,
    input wire logic timer2_int_enable,
    input wire logic rx_baud_tick,
    input wire logic tx_baud_tick,
    input wire logic timer2_irq,
    input wire logic clock_out_pin,
    input wire logic clock_out_oe_n
);
    logic rx_src;
    logic tx_src;
    logic cout_en;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Shadow of software written baud source bits
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_src <= 1'b0;
            tx_src <= 1'b0;
        end else if (reg_write && reg_addr == timer2_pkg::OFFS_CONTROL) begin
            rx_src <= reg_wdata[timer2_pkg::BIT_RX_BAUD_SOURCE];
            tx_src <= reg_wdata[timer2_pkg::BIT_TX_BAUD_SOURCE];
        end
    end

    // Shadow of clock out enable
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cout_en <= 1'b0;
        end else if (reg_write && reg_addr == timer2_pkg::OFFS_MODE) begin
            cout_en <= reg_wdata[timer2_pkg::BIT_CLOCK_OUT_ENABLE];
        end
    end

    a_rx_timer1:
        assert property (!rx_src |=> rx_baud_tick == $past(timer1_overflow)) else $error("rx tick not timer 1");
    a_tx_timer1:
        assert property (!tx_src |=> tx_baud_tick == $past(timer1_overflow)) else $error("tx tick not timer 1");
    a_oe_follows:
        assert property (clock_out_oe_n == !$past(cout_en)) else $error("clock out enable wrong");
    a_pin_quiet:
        assert property (!$past(cout_en) |-> !clock_out_pin) else $error("clock out active while off");
    a_pin_driven:
        assert property (clock_out_pin |-> !clock_out_oe_n) else $error("clock out high undriven");
    a_irq_masked:
        assert property (!$past(timer2_int_enable) |-> !timer2_irq) else $error("irq while disabled");
    a_irq_flags:
        assert property (reg_read && reg_addr == timer2_pkg::OFFS_CONTROL |=>
            timer2_irq == ($past(timer2_int_enable) && (reg_rdata[7] || reg_rdata[6])))
            else $error("irq disagrees with flags");
    a_mode_reserved:
        assert property (reg_read && reg_addr == timer2_pkg::OFFS_MODE |=> reg_rdata[7:2] == 6'h00)
            else $error("mode reserved bits set");
endmodule

bind timer2_capture_reload_control timer2_monitor mon (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .external_trigger_pin(external_trigger_pin), .twelve_clock_mode(twelve_clock_mode),
    .timer1_overflow(timer1_overflow), .timer2_int_enable(timer2_int_enable), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .timer2_irq(timer2_irq), .clock_out_pin(clock_out_pin),
    .clock_out_oe_n(clock_out_oe_n));

// [test/trigger_source.sv]
/*
 Far side model: external trigger pin with pull-up and Timer 1 overflow.
 Assumes the bench calls its tasks; pin idles high.
*/
`timescale 1ns/1ps
module trigger_source (
    // Clock
    input wire logic mclk,
    // Far side lines
    output logic pin,
    output logic t1_ovf
);
    initial begin
        pin = 1'b1;
        t1_ovf = 1'b0;
    end

    task automatic fall();
        @(posedge mclk);
        pin <= 1'b0;
        repeat (4) @(posedge mclk);
        pin <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic level(input logic v);
        @(posedge mclk);
        pin <= v;
    endtask

    task automatic t1();
        @(posedge mclk);
        t1_ovf <= 1'b1;
        @(posedge mclk);
        t1_ovf <= 1'b0;
    endtask
endmodule
